// ### adf_pkg.sv
// shared constants, types and helpers of the demultiplexing output formatter
package adf_pkg;

	// sample word layout
	localparam int CODE_W    = 10;
	localparam int WORD_W    = CODE_W + 1;
	localparam int OOR_BIT   = CODE_W;

	// register byte offsets
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
	localparam logic [7:0] ADDR_GROUPS   = 8'h10;

	// control register fields
	localparam int CTL_W        = 7;
	localparam int CTL_RATIO    = 0;
	localparam int CTL_CLKTYPE  = 1;
	localparam int CTL_STAGGER  = 2;
	localparam int CTL_GRAY     = 3;
	localparam int CTL_PATTERN  = 4;
	localparam int CTL_SELFTEST = 5;
	localparam int CTL_SLEEP    = 6;
	localparam logic [CTL_W-1:0] CTRL_RESET = 7'h01;

	// interrupt status and mask fields
	localparam int EV_W      = 3;
	localparam int EV_GROUP  = 0;
	localparam int EV_OOR    = 1;
	localparam int EV_ST_ERR = 2;
	localparam logic [EV_W-1:0] IRQ_MASK_RESET = 3'h0;

	// self-test words and synchroniser depths
	localparam logic [CODE_W-1:0] ST_EVEN_WORD = 10'h155;
	localparam logic [CODE_W-1:0] ST_ODD_WORD  = 10'h2aa;
	localparam int SYNC_STAGES = 3;
	localparam int RST_STAGES  = 2;

	// sample phase counter within a group of two or four
	localparam logic [1:0] PH_LAST_4 = 2'h3;
	localparam logic [1:0] PH_LAST_2 = 2'h1;
	localparam logic [1:0] PH_MID_4  = 2'h1;
	localparam logic [1:0] PH_MID_2  = 2'h0;

	typedef enum logic [0:0] {DM_SLEEP, DM_RUN} adf_dm_state_type;

	// natural binary to reflected gray
	function automatic logic [CODE_W-1:0] bin2gray(input logic [CODE_W-1:0] b);
		bin2gray = b ^ (b >> 1);
	endfunction

endpackage

// ### adf_conv_stage.sv
// converter stage: sampling clock edge finder, pattern substitution and code format
`timescale 1ns/100ps
module adf_conv_stage #(
	parameter int W = 10
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// pins from the sampling side
	input  wire logic         sample_clk_pin,
	input  wire logic [W-1:0] code_pin,
	input  wire logic         oor_pin,
	// mode controls
	input  wire logic         pattern_en,
	input  wire logic         gray_en,
	// formatted samples
	output logic              smp_valid,
	output logic [W-1:0]      smp_code,
	output logic              smp_oor
);

	localparam int SW = W + 2;

	logic [SW-1:0] s1_q;
	logic [SW-1:0] s2_q;
	logic [SW-1:0] s3_q;
	logic [SW-1:0] filt_q;
	logic          clk_prev_q;
	logic [W-1:0]  pat_q;
	logic          rise;
	logic [W-1:0]  raw_code;

	// three stages; first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= {sample_clk_pin, oor_pin, code_pin};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a bit rises only once stages two and three are both high and falls as soon as they differ, so only one-sample high glitches are rejected
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			filt_q     <= '0;
			clk_prev_q <= 1'b0;
		end else begin
			filt_q     <= (s2_q & s3_q) | (filt_q & ~(s2_q ^ s3_q));
			clk_prev_q <= filt_q[SW-1];
		end
	end

	assign rise = filt_q[SW-1] & ~clk_prev_q;

	// ramp restarts at zero after reset so captures line up with the first acquisition
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pat_q <= '0;
		end else if (rise) begin
			pat_q <= pat_q + 1'b1;
		end
	end

	assign raw_code = pattern_en ? pat_q : filt_q[W-1:0]; // RULE13

	// one word per sampling edge: code plus its out-of-range bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			smp_valid <= 1'b0;
			smp_code  <= '0;
			smp_oor   <= 1'b0;
		end else begin
			smp_valid <= rise; // RULE1
			smp_code  <= gray_en ? adf_pkg::bin2gray(raw_code) : raw_code; // RULE9
			smp_oor   <= pattern_en ? 1'b0 : filt_q[W]; // RULE1
		end
	end

endmodule // adf_conv_stage

// ### adf_output_formatter.sv
// top: demultiplexer, output clocking, self test, registers and interrupt
//
// Overview of operation
// RULE1: every sample leaves as a 10-bit code with its out-of-range bit, kept together to the port.
// RULE2: each port carries one word per two or four samples, depending on the ratio.
// RULE3: the ratio bit picks 1:2 or 1:4 and samples are spread over two or four ports.
// RULE4: in single-edge mode the data-ready clock has one rising edge per output word.
// RULE5: in double-edge mode every edge of the data-ready clock marks a word.
// RULE6: in staggered mode odd ports launch half a word period after even ports.
// RULE7: in simultaneous mode all ports launch together.
// RULE8: in staggered mode each port's extra bit carries its own clock, else its out-of-range bit; in 1:2 the code holds the C and D extra bits low.
// RULE9: the format bit picks natural binary or gray output code.
// RULE10: the out-of-range bit is presented as an eleventh bit beside each word.
// RULE11: the converter reset acts at once and, after release, restarts at port A with the clock aligned.
// RULE12: the demultiplexer reset clears demultiplexer state on its own.
// RULE13: the pattern bit replaces converted samples with a counting ramp.
// RULE14: the self-test bit feeds a fixed word pair through the demultiplexer and checks it.
// RULE15: the sleep bit stops all output activity.
// RULE16: samples go to ports in turn from port A; in 1:2 only A and B carry data.
// RULE17: the capturing logic samples on the marked edges, using per-port clocks when staggered; the link model captures on data-ready rising edges only.
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/100ps
module adf_output_formatter #(
	parameter int CODE_W = adf_pkg::CODE_W
) (
	// clock and resets
	input  wire logic              CLK,
	input  wire logic              RESETN,
	input  wire logic              CONVERTER_RESET_N,
	input  wire logic              DEMUX_ASYNC_RESET,
	// sampling side
	input  wire logic              SAMPLE_CLK,
	input  wire logic [CODE_W-1:0] SAMPLE_CODE,
	input  wire logic              SAMPLE_OOR,
	// register port
	input  wire logic [7:0]        ADDR,
	input  wire logic [31:0]       WDATA,
	input  wire logic              WR,
	input  wire logic              RD,
	output logic [31:0]            RDATA,
	output logic                   IRQ,
	// output ports
	output logic [CODE_W-1:0]      PORT_A_DATA,
	output logic [CODE_W-1:0]      PORT_B_DATA,
	output logic [CODE_W-1:0]      PORT_C_DATA,
	output logic [CODE_W-1:0]      PORT_D_DATA,
	output logic                   PORT_A_EXTRA_BIT,
	output logic                   PORT_B_EXTRA_BIT_OR_CLOCK,
	output logic                   PORT_C_EXTRA_BIT_OR_CLOCK,
	output logic                   PORT_D_EXTRA_BIT_OR_CLOCK,
	output logic                   DATA_READY_CLOCK
);

	localparam int WW = CODE_W + 1;

	logic [adf_pkg::RST_STAGES-1:0] sys_rst_q;
	logic [adf_pkg::RST_STAGES-1:0] cnv_rst_q;
	logic [adf_pkg::RST_STAGES-1:0] dmx_rst_q;
	logic                   rst_n;
	logic                   cv_rst_n;
	logic                   dm_rst_n;
	logic                   al_rst_n;
	logic [adf_pkg::CTL_W-1:0] ctrl_q;
	logic [adf_pkg::EV_W-1:0]  irq_stat_q;
	logic [adf_pkg::EV_W-1:0]  irq_mask_q;
	logic [adf_pkg::EV_W-1:0]  ev;
	logic [31:0]            groups_q;
	logic                   smp_valid;
	logic [CODE_W-1:0]      smp_code;
	logic                   smp_oor;
	adf_pkg::adf_dm_state_type state_q;
	logic [1:0]             ph_q;
	logic [WW-1:0]          buf_q [0:2];
	logic [WW-1:0]          pend_b_q;
	logic [WW-1:0]          pend_d_q;
	logic                   pend_q;
	logic [WW-1:0]          pa_q;
	logic [WW-1:0]          pb_q;
	logic [WW-1:0]          pc_q;
	logic [WW-1:0]          pd_q;
	logic                   ev_clk_q;
	logic                   od_clk_q;
	logic                   st_arm_q;
	logic                   st_chk_ev_q;
	logic                   st_chk_od_q;
	logic                   ratio4;
	logic                   stag;
	logic                   dbl;
	logic                   run;
	logic [1:0]             ph_last;
	logic [1:0]             ph_mid;
	logic [WW-1:0]          in_word;
	logic                   at_last;
	logic                   at_mid;
	logic                   launch_ev;
	logic                   launch_od;
	logic [WW-1:0]          pa_d;
	logic [WW-1:0]          pb_d;
	logic [WW-1:0]          pc_d;
	logic [WW-1:0]          pd_d;
	logic                   ev_clk_d;
	logic                   od_clk_d;
	logic                   st_err;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			sys_rst_q <= '0;
		end else begin
			sys_rst_q <= {sys_rst_q[0], 1'b1};
		end
	end

	always_ff @(posedge CLK or negedge CONVERTER_RESET_N) begin
		if (!CONVERTER_RESET_N) begin
			cnv_rst_q <= '0; // RULE11
		end else begin
			cnv_rst_q <= {cnv_rst_q[0], 1'b1};
		end
	end

	always_ff @(posedge CLK or posedge DEMUX_ASYNC_RESET) begin
		if (DEMUX_ASYNC_RESET) begin
			dmx_rst_q <= '0; // RULE12
		end else begin
			dmx_rst_q <= {dmx_rst_q[0], 1'b1};
		end
	end

	// combined resets: converter side, demux side, and the alignment both share
	assign rst_n    = sys_rst_q[1];
	assign cv_rst_n = rst_n & cnv_rst_q[1];
	assign dm_rst_n = rst_n & dmx_rst_q[1];
	assign al_rst_n = dm_rst_n & cv_rst_n;

	adf_conv_stage #(
		.W (CODE_W)
	) u_conv (
		.clk            (CLK),
		.rst_n          (cv_rst_n),
		.sample_clk_pin (SAMPLE_CLK),
		.code_pin       (SAMPLE_CODE),
		.oor_pin        (SAMPLE_OOR),
		.pattern_en     (ctrl_q[adf_pkg::CTL_PATTERN]),
		.gray_en        (ctrl_q[adf_pkg::CTL_GRAY]),
		.smp_valid      (smp_valid),
		.smp_code       (smp_code),
		.smp_oor        (smp_oor)
	);

	// mode decode
	assign ratio4  = ctrl_q[adf_pkg::CTL_RATIO]; // RULE3
	assign stag    = ctrl_q[adf_pkg::CTL_STAGGER];
	assign dbl     = ctrl_q[adf_pkg::CTL_CLKTYPE];
	assign run     = (state_q == adf_pkg::DM_RUN);
	assign ph_last = ratio4 ? adf_pkg::PH_LAST_4 : adf_pkg::PH_LAST_2;
	assign ph_mid  = ratio4 ? adf_pkg::PH_MID_4 : adf_pkg::PH_MID_2;
	assign at_last = run & smp_valid & (ph_q >= ph_last);
	assign at_mid  = run & smp_valid & (ph_q == ph_mid);

	// self test swaps the converter for a fixed even/odd word pair
	assign in_word = ctrl_q[adf_pkg::CTL_SELFTEST] ?
		{1'b0, (ph_q[0] ? adf_pkg::ST_ODD_WORD : adf_pkg::ST_EVEN_WORD)} :
		{smp_oor, smp_code}; // RULE14

	// launch points: even ports at group end, odd ports with them or half a word later
	assign launch_ev = at_last;
	assign launch_od = stag ? (at_mid & pend_q) : at_last; // RULE6 RULE7

	// next port words and clocks; extra bits must change with the data, not a cycle later
	always_comb begin
		pa_d     = pa_q;
		pb_d     = pb_q;
		pc_d     = pc_q;
		pd_d     = pd_q;
		ev_clk_d = ev_clk_q;
		od_clk_d = od_clk_q;
		if (launch_ev) begin
			pa_d = buf_q[0]; // RULE16
			pc_d = ratio4 ? buf_q[2] : '0; // RULE16
		end
		if (launch_od) begin
			pb_d = stag ? pend_b_q : (ratio4 ? buf_q[1] : in_word);
			pd_d = stag ? pend_d_q : (ratio4 ? in_word : '0);
		end
		if (!run) begin
			ev_clk_d = 1'b0; // RULE15
			od_clk_d = 1'b0;
		end else if (dbl) begin
			if (at_mid) ev_clk_d = ~ev_clk_q; // RULE5
			if (at_last) od_clk_d = ~od_clk_q;
		end else begin
			if (at_last) ev_clk_d = 1'b0; // RULE4
			else if (at_mid) ev_clk_d = 1'b1;
			if (at_mid) od_clk_d = 1'b0;
			else if (at_last) od_clk_d = 1'b1;
		end
	end

	// sleep state follows the control bit
	always_ff @(posedge CLK or negedge dm_rst_n) begin
		if (!dm_rst_n) begin
			state_q <= adf_pkg::DM_RUN;
		end else if (ctrl_q[adf_pkg::CTL_SLEEP]) begin
			state_q <= adf_pkg::DM_SLEEP; // RULE15
		end else begin
			state_q <= adf_pkg::DM_RUN;
		end
	end

	// sample phase: restarts at port A after either reset and while asleep
	always_ff @(posedge CLK or negedge al_rst_n) begin
		if (!al_rst_n) begin
			ph_q <= '0; // RULE11 RULE12
		end else if (!run) begin
			ph_q <= '0;
		end else if (smp_valid) begin
			ph_q <= at_last ? 2'h0 : ph_q + 2'h1; // RULE2
		end
	end

	// collect samples of the group; the last sample goes straight to its port, or to the pending word when staggered
	always_ff @(posedge CLK or negedge dm_rst_n) begin
		if (!dm_rst_n) begin
			buf_q[0] <= '0;
			buf_q[1] <= '0;
			buf_q[2] <= '0;
		end else if (run && smp_valid && !at_last) begin
			buf_q[ph_q] <= in_word; // RULE1 RULE16
		end
	end

	// odd words wait here so the next group can refill the buffer meanwhile
	always_ff @(posedge CLK or negedge al_rst_n) begin
		if (!al_rst_n) begin
			pend_b_q <= '0;
			pend_d_q <= '0;
			pend_q   <= 1'b0;
		end else if (!run) begin
			pend_q <= 1'b0;
		end else if (launch_ev && stag) begin
			pend_b_q <= ratio4 ? buf_q[1] : in_word;
			pend_d_q <= ratio4 ? in_word : '0;
			pend_q   <= 1'b1;
		end else if (launch_od) begin
			pend_q <= 1'b0;
		end
	end

	// port words, clocks and extra bits
	always_ff @(posedge CLK or negedge al_rst_n) begin
		if (!al_rst_n) begin
			pa_q     <= '0;
			pb_q     <= '0;
			pc_q     <= '0;
			pd_q     <= '0;
			ev_clk_q <= 1'b0;
			od_clk_q <= 1'b0;
		end else begin
			pa_q     <= pa_d;
			pb_q     <= pb_d;
			pc_q     <= pc_d;
			pd_q     <= pd_d;
			ev_clk_q <= ev_clk_d;
			od_clk_q <= od_clk_d;
		end
	end

	// output pins, each straight from a flop
	always_ff @(posedge CLK or negedge al_rst_n) begin
		if (!al_rst_n) begin
			PORT_A_DATA               <= '0;
			PORT_B_DATA               <= '0;
			PORT_C_DATA               <= '0;
			PORT_D_DATA               <= '0;
			PORT_A_EXTRA_BIT          <= 1'b0;
			PORT_B_EXTRA_BIT_OR_CLOCK <= 1'b0;
			PORT_C_EXTRA_BIT_OR_CLOCK <= 1'b0;
			PORT_D_EXTRA_BIT_OR_CLOCK <= 1'b0;
			DATA_READY_CLOCK          <= 1'b0;
		end else begin
			PORT_A_DATA               <= pa_d[CODE_W-1:0];
			PORT_B_DATA               <= pb_d[CODE_W-1:0];
			PORT_C_DATA               <= pc_d[CODE_W-1:0];
			PORT_D_DATA               <= pd_d[CODE_W-1:0];
			PORT_A_EXTRA_BIT          <= stag ? ev_clk_d : pa_d[CODE_W]; // RULE8 RULE10
			PORT_B_EXTRA_BIT_OR_CLOCK <= stag ? od_clk_d : pb_d[CODE_W]; // RULE8 RULE10
			// in 1:2 port c and d stay quiet even when staggered
			PORT_C_EXTRA_BIT_OR_CLOCK <= stag ? (ev_clk_d & ratio4) : pc_d[CODE_W]; // RULE8
			PORT_D_EXTRA_BIT_OR_CLOCK <= stag ? (od_clk_d & ratio4) : pd_d[CODE_W]; // RULE8
			DATA_READY_CLOCK          <= ev_clk_d; // RULE4 RULE5
		end
	end

	// self-test check one cycle after a launch; only groups that ran fully in test mode count, except the arming group's odd words when staggered
	always_ff @(posedge CLK or negedge dm_rst_n) begin
		if (!dm_rst_n) begin
			st_arm_q    <= 1'b0;
			st_chk_ev_q <= 1'b0;
			st_chk_od_q <= 1'b0;
		end else begin
			if (!ctrl_q[adf_pkg::CTL_SELFTEST] || !run) begin
				st_arm_q <= 1'b0;
			end else if (launch_ev) begin
				st_arm_q <= 1'b1;
			end
			st_chk_ev_q <= launch_ev & st_arm_q & ctrl_q[adf_pkg::CTL_SELFTEST]; // RULE14
			st_chk_od_q <= launch_od & st_arm_q & ctrl_q[adf_pkg::CTL_SELFTEST]; // RULE14
		end
	end

	assign st_err = (st_chk_ev_q && (pa_q[CODE_W-1:0] != adf_pkg::ST_EVEN_WORD ||
		(ratio4 && pc_q[CODE_W-1:0] != adf_pkg::ST_EVEN_WORD))) ||
		(st_chk_od_q && (pb_q[CODE_W-1:0] != adf_pkg::ST_ODD_WORD ||
		(ratio4 && pd_q[CODE_W-1:0] != adf_pkg::ST_ODD_WORD))); // RULE14

	// events for the interrupt status
	always_comb begin
		ev                     = '0;
		ev[adf_pkg::EV_GROUP]  = launch_ev;
		ev[adf_pkg::EV_OOR]    = run & smp_valid & smp_oor & ~ctrl_q[adf_pkg::CTL_SELFTEST];
		ev[adf_pkg::EV_ST_ERR] = st_err;
	end

	// control and mask registers
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q     <= adf_pkg::CTRL_RESET;
			irq_mask_q <= adf_pkg::IRQ_MASK_RESET;
		end else if (WR) begin
			if (ADDR == adf_pkg::ADDR_CTRL) begin
				ctrl_q <= WDATA[adf_pkg::CTL_W-1:0];
			end else if (ADDR == adf_pkg::ADDR_IRQ_MASK) begin
				irq_mask_q <= WDATA[adf_pkg::EV_W-1:0];
			end
		end
	end

	// sticky status cleared by its read; a new event in that cycle survives
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_q <= '0;
		end else if (RD && ADDR == adf_pkg::ADDR_IRQ_STAT) begin
			irq_stat_q <= ev;
		end else begin
			irq_stat_q <= irq_stat_q | ev;
		end
	end

	// launched group counter, wraps
	always_ff @(posedge CLK or negedge dm_rst_n) begin
		if (!dm_rst_n) begin
			groups_q <= '0;
		end else if (launch_ev) begin
			groups_q <= groups_q + 32'h1;
		end
	end

	// read data one cycle after the strobe; unmapped offsets read zero
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			RDATA <= '0;
		end else if (!RD) begin
			RDATA <= '0;
		end else if (ADDR == adf_pkg::ADDR_CTRL) begin
			RDATA <= {25'h0, ctrl_q};
		end else if (ADDR == adf_pkg::ADDR_STATUS) begin
			RDATA <= {26'h0, st_arm_q, pend_q, ph_q, ev_clk_q, run};
		end else if (ADDR == adf_pkg::ADDR_IRQ_STAT) begin
			RDATA <= {29'h0, irq_stat_q};
		end else if (ADDR == adf_pkg::ADDR_IRQ_MASK) begin
			RDATA <= {29'h0, irq_mask_q};
		end else if (ADDR == adf_pkg::ADDR_GROUPS) begin
			RDATA <= groups_q;
		end else begin
			RDATA <= '0;
		end
	end

	// level interrupt, one cycle behind the status
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(irq_stat_q & irq_mask_q);
		end
	end

endmodule // adf_output_formatter

// ### adf_output_formatter_monitor.sv
// checker of port timing and control readback of the output formatter
`timescale 1ns/100ps
module adf_output_formatter_monitor #(
	parameter int CODE_W = adf_pkg::CODE_W
) (
	// clock and resets
	input wire logic              CLK,
	input wire logic              RESETN,
	input wire logic              CONVERTER_RESET_N,
	input wire logic              DEMUX_ASYNC_RESET,
	// register port
	input wire logic [7:0]        ADDR,
	input wire logic [31:0]       WDATA,
	input wire logic              WR,
	input wire logic              RD,
	input wire logic [31:0]       RDATA,
	input wire logic              IRQ,
	// output ports
	input wire logic [CODE_W-1:0] PORT_A_DATA,
	input wire logic [CODE_W-1:0] PORT_C_DATA,
	input wire logic              PORT_A_EXTRA_BIT,
	input wire logic              PORT_C_EXTRA_BIT_OR_CLOCK,
	input wire logic              DATA_READY_CLOCK
);
	logic [6:0] ctrl_q;
	logic       any_rst;

	// shadow of the control word, rebuilt from bus writes
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ctrl_q <= adf_pkg::CTRL_RESET;
		end else if (WR && ADDR == adf_pkg::ADDR_CTRL) begin
			ctrl_q <= WDATA[6:0];
		end
	end

	// port resets zero the ports, so port-change checks stand aside then
	assign any_rst = !RESETN || !CONVERTER_RESET_N || DEMUX_ASYNC_RESET;

	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);

	// a mode bit seen two cycles running, then a port A launch under it
	sequence s_held(logic b);
		b ##1 b;
	endsequence
	sequence s_launch(logic b);
		s_held(b) ##0 $changed(PORT_A_DATA);
	endsequence

	single_edge_a: assert property (disable iff (any_rst)
		s_launch(!ctrl_q[adf_pkg::CTL_CLKTYPE]) |-> $fell(DATA_READY_CLOCK))
		else $error("launch without falling data-ready clock");
	double_edge_a: assert property (disable iff (any_rst)
		s_launch(ctrl_q[adf_pkg::CTL_CLKTYPE]) |-> $stable(DATA_READY_CLOCK))
		else $error("double-edge clock moved at launch");
	stagger_clock_a: assert property (
		s_held(ctrl_q[adf_pkg::CTL_STAGGER]) |-> PORT_A_EXTRA_BIT == DATA_READY_CLOCK)
		else $error("port a extra bit is not its clock");
	half_ratio_idle_a: assert property (disable iff (any_rst)
		s_held(!ctrl_q[adf_pkg::CTL_RATIO]) |-> !PORT_C_EXTRA_BIT_OR_CLOCK
		&& $stable(PORT_C_DATA)) else $error("port c active in 1:2");
	sleep_quiet_a: assert property (disable iff (any_rst)
		s_held(ctrl_q[adf_pkg::CTL_SLEEP]) |-> !DATA_READY_CLOCK && $stable(PORT_A_DATA))
		else $error("activity while asleep");
	conv_reset_a: assert property (
		!$past(CONVERTER_RESET_N) |-> PORT_A_DATA == '0 && !DATA_READY_CLOCK)
		else $error("converter reset left port a or clock");
	demux_reset_a: assert property (
		$past(DEMUX_ASYNC_RESET) |-> PORT_C_DATA == '0 && !PORT_C_EXTRA_BIT_OR_CLOCK)
		else $error("demux reset left port c");
	ctrl_readback_a: assert property (
		RD && ADDR == adf_pkg::ADDR_CTRL |=> RDATA == {25'h0, $past(ctrl_q)})
		else $error("control readback wrong");
	irq_clear_a: assert property (
		$fell(IRQ) |-> $past(RD, 2) || $past(WR, 2))
		else $error("irq dropped without bus access");
endmodule // adf_output_formatter_monitor

bind adf_output_formatter adf_output_formatter_monitor #(.CODE_W(CODE_W))
	u_adf_output_formatter_monitor (
	.CLK(CLK), .RESETN(RESETN), .CONVERTER_RESET_N(CONVERTER_RESET_N),
	.DEMUX_ASYNC_RESET(DEMUX_ASYNC_RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
	.RD(RD), .RDATA(RDATA), .IRQ(IRQ), .PORT_A_DATA(PORT_A_DATA),
	.PORT_C_DATA(PORT_C_DATA), .PORT_A_EXTRA_BIT(PORT_A_EXTRA_BIT),
	.PORT_C_EXTRA_BIT_OR_CLOCK(PORT_C_EXTRA_BIT_OR_CLOCK),
	.DATA_READY_CLOCK(DATA_READY_CLOCK)
);

// ### adf_link_model.sv
// far side model: sample source on the converter pins and capture of port words
`timescale 1ns/100ps
module adf_link_model (
	// sampling pins
	output logic            sample_clk,
	output logic [9:0]      sample_code,
	output logic            sample_oor,
	// capturing side
	input wire logic        data_ready_clock,
	input wire logic [9:0]  port_a_data,
	input wire logic [9:0]  port_b_data,
	output logic [9:0]      cap_a,
	output logic [9:0]      cap_b
);
	// link clock idles low between samples
	initial begin
		sample_clk = 1'b0;
		sample_code = 10'h000;
		sample_oor = 1'b0;
	end

	// one acquisition; after the hold time the lines show a changed value
	task automatic send(input logic [9:0] code, input logic oor);
		sample_code = code;
		sample_oor = oor;
		#62.5 sample_clk = 1'b1;
		#55 sample_code = ~code;
		sample_oor = ~oor;
		#7.5 sample_clk = 1'b0;
	endtask

	// words are taken on the marked rising edge only
	always @(posedge data_ready_clock) begin
		cap_a <= port_a_data;
		cap_b <= port_b_data;
	end
endmodule // adf_link_model

// ### adf_output_formatter_test.sv
// self-checking testbench of the demultiplexing output formatter
`timescale 1ns/100ps
module adf_output_formatter_test;
	logic        CLK = 1'b0;
	logic        RESETN = 1'b0;
	logic        CONVERTER_RESET_N = 1'b1;
	logic        DEMUX_ASYNC_RESET = 1'b0;
	logic [7:0]  ADDR = 8'h00;
	logic [31:0] WDATA = 32'h0;
	logic        WR = 1'b0;
	logic        RD = 1'b0;
	logic        SAMPLE_CLK, SAMPLE_OOR, IRQ, DATA_READY_CLOCK, xa, xb, xc, xd;
	logic [9:0]  SAMPLE_CODE, pa, pb, pc, pd, cap_a, cap_b;
	logic [9:0]  pw [4];
	logic [31:0] RDATA, rv;
	logic        drc_q = 1'b0;
	int          fails = 0, cmp_count = 0, cyc = 0, toggles = 0, t0;

	adf_output_formatter u_adf_output_formatter (
		.CLK(CLK), .RESETN(RESETN), .CONVERTER_RESET_N(CONVERTER_RESET_N),
		.DEMUX_ASYNC_RESET(DEMUX_ASYNC_RESET), .SAMPLE_CLK(SAMPLE_CLK),
		.SAMPLE_CODE(SAMPLE_CODE), .SAMPLE_OOR(SAMPLE_OOR), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .PORT_A_DATA(pa), .PORT_B_DATA(pb),
		.PORT_C_DATA(pc), .PORT_D_DATA(pd), .PORT_A_EXTRA_BIT(xa),
		.PORT_B_EXTRA_BIT_OR_CLOCK(xb), .PORT_C_EXTRA_BIT_OR_CLOCK(xc),
		.PORT_D_EXTRA_BIT_OR_CLOCK(xd), .DATA_READY_CLOCK(DATA_READY_CLOCK)
	);
	adf_link_model u_adf_link_model (
		.sample_clk(SAMPLE_CLK), .sample_code(SAMPLE_CODE), .sample_oor(SAMPLE_OOR),
		.data_ready_clock(DATA_READY_CLOCK), .port_a_data(pa), .port_b_data(pb),
		.cap_a(cap_a), .cap_b(cap_b)
	);

	// clock source
	always #5 CLK = ~CLK;

	// data-ready edge count and a run ceiling well above the test length
	always @(posedge CLK) begin
		drc_q <= DATA_READY_CLOCK;
		toggles <= toggles + ((DATA_READY_CLOCK !== drc_q) ? 1 : 0);
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			results();
		end
	end

	function automatic logic [31:0] gray(input logic [9:0] b);
		gray = {22'h0, b ^ (b >> 1)};
	endfunction

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1 rv = RDATA;
	endtask

	// samples base, base+1, ...; the last may carry out-of-range
	task automatic burst(input int n, input logic [9:0] base, input logic oor_last);
		for (int i = 0; i < n; i++)
			u_adf_link_model.send(base + 10'(i), oor_last && i == n - 1);
		repeat (8) @(posedge CLK);
	endtask

	task automatic rst_pulse(input logic dmx);
		@(posedge CLK);
		if (dmx)
			DEMUX_ASYNC_RESET <= 1'b1;
		else
			CONVERTER_RESET_N <= 1'b0;
		@(posedge CLK);
		DEMUX_ASYNC_RESET <= 1'b0;
		CONVERTER_RESET_N <= 1'b1;
		repeat (4) @(posedge CLK);
	endtask

	task automatic done(input string t);
		$display("test %s done, mismatches so far %0d", t, fails);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge CLK);
		RESETN <= 1'b1;
		repeat (3) @(posedge CLK);
		rd(adf_pkg::ADDR_CTRL);
		chk("ctrl reset", rv, 32'h1);
		rd(adf_pkg::ADDR_IRQ_MASK);
		chk("mask reset", rv, 32'h0);
		rd(8'hfc);
		chk("unmapped", rv, 32'h0);
		wr(adf_pkg::ADDR_IRQ_MASK, 32'h1);
		done("registers");
		t0 = toggles;
		burst(4, 10'h100, 1'b1);
		pw = '{pa, pb, pc, pd};
		for (int i = 0; i < 4; i++)
			chk("port word", {22'h0, pw[i]}, 32'h100 + i);
		chk("a extra", {31'h0, xa}, 32'h0);
		chk("d extra", {31'h0, xd}, 32'h1);
		chk("single edges", toggles - t0, 2);
		chk("irq", {31'h0, IRQ}, 32'h1);
		rd(adf_pkg::ADDR_IRQ_STAT);
		chk("events", rv, 32'h3);
		@(posedge CLK);
		#1 chk("irq cleared", {31'h0, IRQ}, 32'h0);
		done("ratio 1:4");
		wr(adf_pkg::ADDR_CTRL, 32'h8);
		burst(1, 10'h3c0, 1'b0);
		rst_pulse(1'b0);
		burst(3, 10'h0f3, 1'b0);
		chk("a gray", {22'h0, pa}, gray(10'h0f3));
		chk("b gray", {22'h0, pb}, gray(10'h0f4));
		chk("captured a", {22'h0, cap_a}, gray(10'h0f3));
		chk("captured b", {22'h0, cap_b}, gray(10'h0f4));
		chk("c extra", {31'h0, xc}, 32'h0);
		rst_pulse(1'b1);
		chk("a cleared", {22'h0, pa}, 32'h0);
		rd(adf_pkg::ADDR_CTRL);
		chk("ctrl kept", rv, 32'h8);
		done("ratio 1:2 gray and resets");
		wr(adf_pkg::ADDR_CTRL, 32'h5);
		burst(4, 10'h200, 1'b0);
		chk("even first", {22'h0, pc}, 32'h202);
		chk("odd later", {22'h0, pb}, 32'h0);
		chk("b clock", {31'h0, xb}, 32'h1);
		burst(2, 10'h210, 1'b0);
		chk("odd launch", {22'h0, pd}, 32'h203);
		chk("even held", {22'h0, pa}, 32'h200);
		done("staggered");
		wr(adf_pkg::ADDR_CTRL, 32'h3);
		rst_pulse(1'b1);
		t0 = toggles;
		burst(8, 10'h040, 1'b0);
		chk("double edges", toggles - t0, 2);
		chk("a together", {22'h0, pa}, 32'h044);
		chk("d together", {22'h0, pd}, 32'h047);
		rd(adf_pkg::ADDR_GROUPS);
		chk("groups", rv, 32'h2);
		done("double edge");
		wr(adf_pkg::ADDR_CTRL, 32'h11);
		rst_pulse(1'b0);
		burst(4, 10'h3ff, 1'b0);
		pw = '{pa, pb, pc, pd};
		for (int i = 0; i < 4; i++)
			chk("pattern", {22'h0, pw[i]}, i);
		wr(adf_pkg::ADDR_CTRL, 32'h21);
		rst_pulse(1'b1);
		rd(adf_pkg::ADDR_IRQ_STAT);
		burst(8, 10'h000, 1'b0);
		pw = '{pa, pb, pc, pd};
		for (int i = 0; i < 4; i++)
			chk("self test", {22'h0, pw[i]}, i[0] ? adf_pkg::ST_ODD_WORD : adf_pkg::ST_EVEN_WORD);
		rd(adf_pkg::ADDR_IRQ_STAT);
		chk("no mismatch", rv, 32'h1);
		done("pattern and self test");
		wr(adf_pkg::ADDR_CTRL, 32'h41);
		burst(4, 10'h123, 1'b0);
		chk("sleep hold", {22'h0, pa}, {22'h0, adf_pkg::ST_EVEN_WORD});
		chk("sleep clock", {31'h0, DATA_READY_CLOCK}, 32'h0);
		rd(adf_pkg::ADDR_STATUS);
		chk("status asleep", rv, 32'h0);
		done("sleep");
		results();
	end
endmodule // adf_output_formatter_test
